//--- logic/boot_strap_pin_defaults.sv
// reset, boot-mode selection and default pin configuration
`timescale 1ns/1ps
module boot_strap_pin_defaults #(
  parameter longint HOLD_CYCLES = boot_strap_pkg::RESET_HOLD_CYCLES,
  parameter longint CAL_CYCLES  = boot_strap_pkg::CAL_PERIOD_CYCLES
) (
  // clock and reset
  input  wire logic                        CLK,
  input  wire logic                        RESET,
  input  wire logic                        MODULE_RESET_LOW,
  // boot inputs
  input  wire logic                        SCRIPT_PRESENT,
  // pads
  input  wire boot_strap_pkg::pin_vec_type PIN_IN,
  output boot_strap_pkg::pin_vec_type      PIN_OUT,
  output boot_strap_pkg::pin_vec_type      PIN_OE,
  output boot_strap_pkg::pin_vec_type      PIN_PULLUP,
  output boot_strap_pkg::pin_vec_type      PIN_PULLDOWN,
  output boot_strap_pkg::pin_vec_type      PIN_ALT,
  // software pin configuration
  input  wire logic                        CFG_WR,
  input  wire logic [4:0]                  CFG_PIN,
  input  wire logic                        CFG_OE,
  input  wire logic                        CFG_OUT,
  input  wire logic                        CFG_PU,
  input  wire logic                        CFG_PD,
  // software peripheral selection
  input  wire logic                        UART_CLOSE,
  input  wire logic                        I2C_OPEN,
  input  wire logic                        SPI_OPEN,
  input  wire logic                        OPEN_EXT_FLASH_CALL,
  // peripheral data
  input  wire logic                        UART_TXD,
  input  wire logic                        RTS_REQ,
  input  wire logic                        I2C_SCL_LOW,
  input  wire logic                        I2C_SDA_LOW,
  input  wire logic                        SPI_SCK,
  input  wire logic                        EXT_FLASH_SELECT,
  input  wire logic                        FLASH_SCK,
  input  wire logic                        FLASH_SI,
  output logic                             UART_RXD,
  output logic                             CTS_ASSERTED,
  output logic                             FLASH_SO,
  // status
  output boot_strap_pkg::boot_mode_type    BOOT_MODE,
  output logic                             MODE_VALID,
  output logic                             IN_RESET,
  output logic                             CAL_START
);
  import boot_strap_pkg::*;

  localparam int HW = $clog2(HOLD_CYCLES + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

  typedef struct packed {
    logic [HW-1:0] hold_cnt;
    logic          in_reset;
    logic          capture;
    logic          mode_valid;
    boot_mode_type mode;
    pin_vec_type   cfg_oe;
    pin_vec_type   cfg_out;
    pin_vec_type   cfg_pu;
    pin_vec_type   cfg_pd;
    pin_vec_type   pin_out;
    pin_vec_type   pin_oe;
    pin_vec_type   pin_pu;
    pin_vec_type   pin_pd;
    pin_vec_type   pin_alt;
    logic          uart_rxd;
    logic          cts_asserted;
    logic          flash_so;
    logic          cal_start;
  } state_type;

  localparam state_type RESET_STATE = '{
    hold_cnt:     '0,
    in_reset:     1'b1,
    capture:      1'b0,
    mode_valid:   1'b0,
    mode:         MODE_COMMAND,
    cfg_oe:       DEF_OE,
    cfg_out:      DEF_OUT,
    cfg_pu:       DEF_PU,
    cfg_pd:       DEF_PD,
    pin_out:      DEF_OUT,
    pin_oe:       DEF_OE,
    pin_pu:       DEF_PU,
    pin_pd:       DEF_PD,
    pin_alt:      '0,
    uart_rxd:     1'b1,
    cts_asserted: 1'b0,
    flash_so:     1'b0,
    cal_start:    1'b0
  };

  state_type state_reg;
  state_type state_next;

  logic cal_tick;
  logic uart_on;
  logic held_long;

  // pads whose internal pulls must stay off
  pin_vec_type no_pull;

  strap_if st ();

  //////////////////////////////////////////////////////////////////////////
  // strap sampling and oscillator calibration tick

  // straps come straight off their own pads
  assign st.self_run_raw = PIN_IN[PIN_SELF_RUN];
  assign st.ota_raw      = PIN_IN[PIN_OTA_STRAP];
  assign st.capture      = state_reg.capture;

  strap_sampler u_sampler (
    .clk   (CLK),
    .reset (RESET),
    .st    (st.sampler)
  );

  // periodic rc recalibration request
  period_timer #(
    .PERIOD (CAL_CYCLES)
  ) u_cal_timer (
    .clk   (CLK),
    .reset (RESET),
    .tick  (cal_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // uart function active once the boot mode is valid, unless autorun runs or software closed it
  assign uart_on = state_reg.mode_valid && !UART_CLOSE &&
                   (state_reg.mode != MODE_SELF_RUN);

  // reset pin counted low for the full hold time
  assign held_long = (state_reg.hold_cnt == HOLD_LAST);

  //////////////////////////////////////////////////////////////////////////
  // pads lent to i2c, spi or flash never keep an internal pull
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_no_pull
    assign no_pull[i] = (I2C_OPEN && (i == PIN_I2C_SCL ||
                                      i == PIN_I2C_SDA)) ||
                        (SPI_OPEN && i == PIN_SPI_CLK) ||
                        (OPEN_EXT_FLASH_CALL && (i == PIN_FLASH_CS  ||
                                                 i == PIN_FLASH_CLK ||
                                                 i == PIN_FLASH_SI  ||
                                                 i == PIN_FLASH_SO));
  end // g_no_pull

  //////////////////////////////////////////////////////////////////////////
  // next state: reset hold, boot decision, pin configuration
  always_comb begin
    state_next           = state_reg;
    state_next.capture   = 1'b0;
    state_next.cal_start = cal_tick;

    // reset pin low time counter, saturating
    if (MODULE_RESET_LOW) begin
      state_next.hold_cnt = '0;
    end else if (!held_long) begin
      state_next.hold_cnt = state_reg.hold_cnt + HW'(1);
    end

    // stay in reset while a long low lasts, release on its rise
    if (!MODULE_RESET_LOW && held_long) begin
      state_next          = RESET_STATE;
      state_next.hold_cnt = state_reg.hold_cnt;
    end else if (state_reg.in_reset) begin
      state_next.in_reset = 1'b0;
      state_next.capture  = 1'b1;
    end

    // calibration keeps its pace through a held reset
    state_next.cal_start = cal_tick;

    // single boot decision from the captured straps
    if (st.done) begin
      state_next.mode_valid = 1'b1;
      if (st.ota_high && !st.self_run_low) begin
        state_next.mode = MODE_BRIDGE;
      end else if (st.self_run_low && SCRIPT_PRESENT) begin
        state_next.mode = MODE_SELF_RUN;
      end else if (st.ota_high) begin
        state_next.mode = MODE_OTA;
      end else begin
        state_next.mode = MODE_COMMAND;
      end
    end

    // software pin writes; any spare pin may serve as spi select
    if (CFG_WR && !state_reg.in_reset && !state_next.in_reset) begin
      state_next.cfg_oe[CFG_PIN]  = CFG_OE;
      state_next.cfg_out[CFG_PIN] = CFG_OUT;
      state_next.cfg_pu[CFG_PIN]  = CFG_PU;
      state_next.cfg_pd[CFG_PIN]  = CFG_PD;
    end

    // digital function: pads follow the configuration
    state_next.pin_oe  = state_next.cfg_oe;
    state_next.pin_out = state_next.cfg_out;
    state_next.pin_pu  = state_next.cfg_pu;
    state_next.pin_pd  = state_next.cfg_pd;
    state_next.pin_alt = '0;

    // uart function on its four pins
    if (uart_on && !state_next.in_reset) begin
      state_next.pin_alt[PIN_UART_TX]  = 1'b1;
      state_next.pin_alt[PIN_UART_RTS] = 1'b1;
      state_next.pin_alt[PIN_UART_RX]  = 1'b1;
      state_next.pin_alt[PIN_UART_CTS] = 1'b1;
      state_next.pin_oe[PIN_UART_TX]   = 1'b1;
      state_next.pin_out[PIN_UART_TX]  = UART_TXD;
      state_next.pin_oe[PIN_UART_RTS]  = 1'b1;
      state_next.pin_out[PIN_UART_RTS] = ~RTS_REQ;
      state_next.pin_oe[PIN_UART_RX]   = 1'b0;
      state_next.pin_oe[PIN_UART_CTS]  = 1'b0;
    end

    // i2c: open drain, pulls left to the board
    if (I2C_OPEN && !state_next.in_reset) begin
      state_next.pin_alt[PIN_I2C_SCL] = 1'b1;
      state_next.pin_alt[PIN_I2C_SDA] = 1'b1;
      state_next.pin_out[PIN_I2C_SCL] = 1'b0;
      state_next.pin_out[PIN_I2C_SDA] = 1'b0;
      state_next.pin_oe[PIN_I2C_SCL]  = I2C_SCL_LOW;
      state_next.pin_oe[PIN_I2C_SDA]  = I2C_SDA_LOW;
      state_next.pin_pu[PIN_I2C_SCL]  = 1'b0;
      state_next.pin_pu[PIN_I2C_SDA]  = 1'b0;
      state_next.pin_pd[PIN_I2C_SCL]  = 1'b0;
      state_next.pin_pd[PIN_I2C_SDA]  = 1'b0;
    end

    // spi master clock
    if (SPI_OPEN && !state_next.in_reset) begin
      state_next.pin_alt[PIN_SPI_CLK] = 1'b1;
      state_next.pin_oe[PIN_SPI_CLK]  = 1'b1;
      state_next.pin_out[PIN_SPI_CLK] = SPI_SCK;
      state_next.pin_pu[PIN_SPI_CLK]  = 1'b0;
      state_next.pin_pd[PIN_SPI_CLK]  = 1'b0;
    end

    // external flash only once software opens it
    if (OPEN_EXT_FLASH_CALL && !state_next.in_reset) begin
      state_next.pin_alt[PIN_FLASH_CS]  = 1'b1;
      state_next.pin_alt[PIN_FLASH_CLK] = 1'b1;
      state_next.pin_alt[PIN_FLASH_SI]  = 1'b1;
      state_next.pin_alt[PIN_FLASH_SO]  = 1'b1;
      state_next.pin_oe[PIN_FLASH_CS]   = 1'b1;
      state_next.pin_oe[PIN_FLASH_CLK]  = 1'b1;
      state_next.pin_oe[PIN_FLASH_SI]   = 1'b1;
      state_next.pin_oe[PIN_FLASH_SO]   = 1'b0;
      state_next.pin_out[PIN_FLASH_CS]  = ~EXT_FLASH_SELECT;
      state_next.pin_out[PIN_FLASH_CLK] = FLASH_SCK;
      state_next.pin_out[PIN_FLASH_SI]  = FLASH_SI;
      state_next.pin_pu[PIN_FLASH_CS]   = 1'b0;
      state_next.pin_pu[PIN_FLASH_CLK]  = 1'b0;
      state_next.pin_pu[PIN_FLASH_SI]   = 1'b0;
      state_next.pin_pu[PIN_FLASH_SO]   = 1'b0;
      state_next.pin_pd[PIN_FLASH_CS]   = 1'b0;
      state_next.pin_pd[PIN_FLASH_CLK]  = 1'b0;
      state_next.pin_pd[PIN_FLASH_SI]   = 1'b0;
      state_next.pin_pd[PIN_FLASH_SO]   = 1'b0;
    end

    // last word on pulls for every pad lent to i2c, spi or flash
    if (!state_next.in_reset) begin
      state_next.pin_pu = state_next.pin_pu & ~no_pull;
      state_next.pin_pd = state_next.pin_pd & ~no_pull;
    end

    // received data back to the user side
    state_next.uart_rxd     = uart_on ? PIN_IN[PIN_UART_RX] : 1'b1;
    state_next.cts_asserted = uart_on & ~PIN_IN[PIN_UART_CTS];
    state_next.flash_so     = OPEN_EXT_FLASH_CALL & PIN_IN[PIN_FLASH_SO];
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= RESET_STATE;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  assign PIN_OUT      = state_reg.pin_out;
  assign PIN_OE       = state_reg.pin_oe;
  assign PIN_PULLUP   = state_reg.pin_pu;
  assign PIN_PULLDOWN = state_reg.pin_pd;
  assign PIN_ALT      = state_reg.pin_alt;
  assign UART_RXD     = state_reg.uart_rxd;
  assign CTS_ASSERTED = state_reg.cts_asserted;
  assign FLASH_SO     = state_reg.flash_so;
  assign BOOT_MODE    = state_reg.mode;
  assign MODE_VALID   = state_reg.mode_valid;
  assign IN_RESET     = state_reg.in_reset;
  assign CAL_START    = state_reg.cal_start;

endmodule // boot_strap_pin_defaults

//--- logic/boot_strap_pkg.sv
// constants, types and pin defaults for the boot strap and pin default block
package boot_strap_pkg;

  // clock and timing
  localparam longint CLK_HZ            = 40000000;
  localparam longint RESET_HOLD_MS     = 100;
  localparam longint RESET_HOLD_CYCLES = (CLK_HZ * RESET_HOLD_MS + 999) / 1000;
  localparam longint CAL_PERIOD_S      = 8;
  localparam longint CAL_PERIOD_CYCLES = CLK_HZ * CAL_PERIOD_S;
  localparam int     CAL_PPM_LIMIT     = 250;

  // pin count and positions
  localparam int NUM_PINS      = 32;
  localparam int PIN_OTA_STRAP = 2;
  localparam int PIN_UART_RTS  = 5;
  localparam int PIN_UART_TX   = 6;
  localparam int PIN_UART_CTS  = 7;
  localparam int PIN_UART_RX   = 8;
  localparam int PIN_FLASH_CS  = 12;
  localparam int PIN_SELF_RUN  = 13;
  localparam int PIN_FLASH_SO  = 14;
  localparam int PIN_FLASH_CLK = 16;
  localparam int PIN_FLASH_SI  = 20;
  localparam int PIN_SPI_CLK   = 25;
  localparam int PIN_I2C_SDA   = 26;
  localparam int PIN_I2C_SCL   = 27;

  // reset values of the pin configuration
  localparam logic [31:0] DEF_OE  = 32'h0000_0060;
  localparam logic [31:0] DEF_OUT = 32'h0000_0040;
  localparam logic [31:0] DEF_PU  = 32'hffff_df1b;
  localparam logic [31:0] DEF_PD  = 32'h0000_2084;

  // boot paths
  typedef enum logic [1:0] {
    MODE_COMMAND  = 2'b00,
    MODE_SELF_RUN = 2'b01,
    MODE_OTA      = 2'b10,
    MODE_BRIDGE   = 2'b11
  } boot_mode_type;

  typedef logic [NUM_PINS-1:0] pin_vec_type;

endpackage

//--- logic/period_timer.sv
// free-running period counter giving a one-cycle tick
`timescale 1ns/1ps
module period_timer #(
  parameter longint PERIOD = 320000000
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // tick out
  output logic      tick
);
  import boot_strap_pkg::*;

  localparam int CW = $clog2(PERIOD + 1);
  localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } state_type;

  state_type state_reg;
  state_type state_next;

  // count to the period, tick on wrap
  always_comb begin
    state_next      = state_reg;
    state_next.tick = 1'b0;
    if (state_reg.cnt == LAST) begin
      state_next.cnt  = '0;
      state_next.tick = 1'b1;
    end else begin
      state_next.cnt = state_reg.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick = state_reg.tick;
endmodule // period_timer

//--- logic/strap_if.sv
// strap levels and captured boot straps between top and sampler
`timescale 1ns/1ps
interface strap_if;
  logic self_run_raw;
  logic ota_raw;
  logic capture;
  logic self_run_low;
  logic ota_high;
  logic done;

  modport sampler (input  self_run_raw, ota_raw, capture,
                   output self_run_low, ota_high, done);
  modport user    (output self_run_raw, ota_raw, capture,
                   input  self_run_low, ota_high, done);
endinterface // strap_if

//--- logic/strap_sampler.sv
// two-flop strap synchroniser with one-shot capture
`timescale 1ns/1ps
module strap_sampler (
  // clock and reset
  input wire logic    clk,
  input wire logic    reset,
  // strap carrier
  strap_if.sampler    st
);
  import boot_strap_pkg::*;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic       self_run_low;
    logic       ota_high;
    logic       done;
  } state_type;

  state_type state_reg;
  state_type state_next;

  //////////////////////////////////////////////////////////////////////////
  // sync chain, capture only on the release pulse
  always_comb begin
    state_next       = state_reg;
    state_next.meta  = {st.self_run_raw, st.ota_raw};
    state_next.sync  = state_reg.meta;
    state_next.done  = 1'b0;
    if (st.capture) begin
      state_next.self_run_low = ~state_reg.sync[1];
      state_next.ota_high     = state_reg.sync[0];
      state_next.done         = 1'b1;
    end
    if (reset) begin                             // decision only, not chain
      state_next.self_run_low = 1'b0;
      state_next.ota_high     = 1'b0;
      state_next.done         = 1'b0;
    end
  end

  // chain runs through reset so the straps settle before release
  always_ff @(posedge clk) begin
    state_reg <= state_next;
  end

  assign st.self_run_low = state_reg.self_run_low;
  assign st.ota_high     = state_reg.ota_high;
  assign st.done         = state_reg.done;
endmodule // strap_sampler

//--- tb/boot_strap_monitor.sv
// concurrent checks on the ports of the boot strap and pin default block
`timescale 1ns/1ps
module boot_strap_monitor #(
  parameter longint HOLD_CYCLES = 8,
  parameter longint CAL_CYCLES  = 16
) (
  // clock and resets
  input wire logic                          CLK,
  input wire logic                          RESET,
  input wire logic                          MODULE_RESET_LOW,
  // boot and peripheral inputs
  input wire logic                          SCRIPT_PRESENT,
  input wire logic                          UART_CLOSE,
  input wire logic                          OPEN_EXT_FLASH_CALL,
  input wire logic                          UART_TXD,
  input wire logic                          RTS_REQ,
  // pads
  input wire boot_strap_pkg::pin_vec_type   PIN_IN,
  input wire boot_strap_pkg::pin_vec_type   PIN_OUT,
  input wire boot_strap_pkg::pin_vec_type   PIN_OE,
  input wire boot_strap_pkg::pin_vec_type   PIN_PULLUP,
  input wire boot_strap_pkg::pin_vec_type   PIN_PULLDOWN,
  input wire boot_strap_pkg::pin_vec_type   PIN_ALT,
  // status
  input wire logic                          CTS_ASSERTED,
  input wire boot_strap_pkg::boot_mode_type BOOT_MODE,
  input wire logic                          MODE_VALID,
  input wire logic                          IN_RESET,
  input wire logic                          CAL_START
);
  import boot_strap_pkg::*;
  logic [15:0] lo_cnt_reg;  // consecutive low samples of the reset pin
  logic [15:0] cal_cnt_reg; // cycles since the last calibration pulse
  logic        cal_seen_reg;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // helper counters for the long timings
  always_ff @(posedge CLK) begin
    lo_cnt_reg   <= MODULE_RESET_LOW ? 16'h0000 :
                    lo_cnt_reg + 16'(lo_cnt_reg != 16'hffff);
    cal_cnt_reg  <= (RESET || CAL_START) ? 16'h0000 : cal_cnt_reg + 16'h0001;
    cal_seen_reg <= (RESET || IN_RESET) ? 1'b0 : (cal_seen_reg || CAL_START);
  end
  ////////////////////////////////////////////////////////////////////////////
  a_reset_pin_defaults: assert property (
    IN_RESET |-> PIN_OE == DEF_OE && PIN_OUT == DEF_OUT && PIN_ALT == '0 &&
    PIN_PULLUP == DEF_PU && PIN_PULLDOWN == DEF_PD)
    else $error("pin defaults lost in reset");
  a_hold_enters_reset: assert property (
    lo_cnt_reg >= 16'(HOLD_CYCLES + 1) |-> IN_RESET)
    else $error("long reset pin low not taken");
  a_short_low_ignored: assert property (
    $rose(IN_RESET) |-> $past(RESET) || lo_cnt_reg >= 16'(HOLD_CYCLES - 2))
    else $error("reset entered on a short low");
  a_mode_after_capture: assert property (
    $fell(IN_RESET) |-> !MODE_VALID ##1 !MODE_VALID ##1 MODE_VALID)
    else $error("boot decision not at third edge");
  a_boot_mode_decode: assert property (
    $rose(MODE_VALID) |-> BOOT_MODE == (PIN_IN[2] && PIN_IN[13] ? MODE_BRIDGE
    : !PIN_IN[13] && SCRIPT_PRESENT ? MODE_SELF_RUN
    : PIN_IN[2] ? MODE_OTA : MODE_COMMAND))
    else $error("wrong boot mode");
  a_self_run_gpio: assert property (
    MODE_VALID && BOOT_MODE == MODE_SELF_RUN |-> PIN_ALT[8:5] == 4'h0)
    else $error("uart pins taken in self run");
  a_uart_drive_lines: assert property (
    MODE_VALID && BOOT_MODE != MODE_SELF_RUN && !UART_CLOSE |=> IN_RESET ||
    (PIN_ALT[6] && PIN_OE[6] && PIN_OUT[6] == $past(UART_TXD) &&
    PIN_OE[5] && PIN_OUT[5] == !$past(RTS_REQ)))
    else $error("uart tx or rts not driven");
  a_cts_active_low: assert property (
    CTS_ASSERTED |-> !$past(PIN_IN[7]))
    else $error("cts asserted on a high pad");
  a_alt_no_pulls: assert property (
    (PIN_ALT & 32'hffff_fe1f & (PIN_PULLUP | PIN_PULLDOWN)) == '0)
    else $error("pull left on alternate pin");
  a_flash_gpio_default: assert property (
    !$past(OPEN_EXT_FLASH_CALL) |-> (PIN_ALT & 32'h0011_5000) == '0)
    else $error("flash pins taken unopened");
  a_cal_period: assert property (
    cal_seen_reg && !IN_RESET |->
    CAL_START == (cal_cnt_reg == 16'(CAL_CYCLES - 1)))
    else $error("calibration pulse off period");
endmodule // boot_strap_monitor

bind boot_strap_pin_defaults boot_strap_monitor #(
  .HOLD_CYCLES(HOLD_CYCLES),
  .CAL_CYCLES (CAL_CYCLES)
) mon_u (.*);

//--- tb/host_pad_model.sv
// host side of the pads: strap drive and resolved pad levels
`timescale 1ns/1ps
module host_pad_model (
  // block pad controls
  input  wire boot_strap_pkg::pin_vec_type pin_out,
  input  wire boot_strap_pkg::pin_vec_type pin_oe,
  input  wire boot_strap_pkg::pin_vec_type pin_pu,
  input  wire boot_strap_pkg::pin_vec_type pin_pd,
  // host drive of each pad
  input  wire boot_strap_pkg::pin_vec_type host_en,
  input  wire boot_strap_pkg::pin_vec_type host_val,
  input  wire logic                        clk,
  output boot_strap_pkg::pin_vec_type      pin_in
);
  import boot_strap_pkg::*;
  logic tog_reg = 1'b0;
  // floating pads wander so no stale level is seen
  always @(posedge clk) tog_reg <= ~tog_reg;
  // block drive first, then host straps, then pulls
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (host_en[i]) pin_in[i] = host_val[i];
      else if (pin_pu[i]) pin_in[i] = 1'b1;
      else if (pin_pd[i]) pin_in[i] = 1'b0;
      else pin_in[i] = tog_reg ^ i[0];
    end
  end
endmodule // host_pad_model

//--- tb/tb_boot_strap_pin_defaults.sv
// self-checking bench for the boot strap and pin default block
`timescale 1ns/1ps
module tb_boot_strap_pin_defaults;
  import boot_strap_pkg::*;
  typedef struct {
    logic [1:0] en, val; // bit 1 self-run strap, bit 0 download strap
    logic scr;
    boot_mode_type mode;
  } row_type;
  row_type rows [7] = '{'{2'b11, 2'b00, 1'b1, MODE_SELF_RUN},
    '{2'b11, 2'b00, 1'b0, MODE_COMMAND}, '{2'b11, 2'b01, 1'b0, MODE_OTA},
    '{2'b11, 2'b01, 1'b1, MODE_SELF_RUN}, '{2'b11, 2'b11, 1'b1, MODE_BRIDGE},
    '{2'b00, 2'b00, 1'b1, MODE_SELF_RUN}, '{2'b11, 2'b10, 1'b1, MODE_COMMAND}};
  logic CLK = 1'b0, RESET = 1'b1, MODULE_RESET_LOW = 1'b1;
  logic SCRIPT_PRESENT = 1'b0, CFG_WR = 1'b0;
  logic [4:0] CFG_PIN = 5'h03;
  logic CFG_OE = 1'b1, CFG_OUT = 1'b1, CFG_PU = 1'b0, CFG_PD = 1'b0;
  logic UART_CLOSE = 1'b0, I2C_OPEN = 1'b0, SPI_OPEN = 1'b0;
  logic OPEN_EXT_FLASH_CALL = 1'b0, UART_TXD = 1'b1, RTS_REQ = 1'b0;
  logic I2C_SCL_LOW = 1'b0, I2C_SDA_LOW = 1'b0, SPI_SCK = 1'b0;
  logic EXT_FLASH_SELECT = 1'b0, FLASH_SCK = 1'b0, FLASH_SI = 1'b0;
  logic UART_RXD, CTS_ASSERTED, FLASH_SO, MODE_VALID, IN_RESET, CAL_START;
  pin_vec_type PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP, PIN_PULLDOWN, PIN_ALT;
  pin_vec_type hen = '0, hval = '0;
  boot_mode_type BOOT_MODE;
  int error_cnt = 0, n_tests = 0, k = 0;
  boot_strap_pin_defaults #(.HOLD_CYCLES(8), .CAL_CYCLES(16)) dut_u (.*);
  host_pad_model host_u (.pin_out(PIN_OUT), .pin_oe(PIN_OE),
    .pin_pu(PIN_PULLUP), .pin_pd(PIN_PULLDOWN), .host_en(hen),
    .host_val(hval), .clk(CLK), .pin_in(PIN_IN));
  // 40 MHz clock
  initial begin
    forever #12.5 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////////
  // step n edges, then settle 1 ns
  task automatic cyc(int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wait_valid();
    int w;
    w = 0;
    while (MODE_VALID !== 1'b1 && w < 20) begin
      cyc(1);
      w++;
    end
    if (MODE_VALID !== 1'b1) begin
      error_cnt++;
      $display("unexpected mode_valid timeout");
      print_verdict();
    end
  endtask
  // main sequence
  initial begin
    cyc(20);
    foreach (rows[i]) begin
      hen[13] = rows[i].en[1];
      hen[2] = rows[i].en[0];
      hval[13] = rows[i].val[1];
      hval[2] = rows[i].val[0];
      SCRIPT_PRESENT = rows[i].scr;
      RESET = 1'b1;
      cyc(4);
      chk("oe", DEF_OE, PIN_OE);
      chk("out", DEF_OUT, PIN_OUT);
      chk("pu", DEF_PU, PIN_PULLUP);
      chk("pd", DEF_PD, PIN_PULLDOWN);
      RESET = 1'b0;
      wait_valid();
      chk("mode", rows[i].mode, BOOT_MODE);
      // uart function lands one edge after the decision
      cyc(1);
      chk("alt", rows[i].mode == MODE_SELF_RUN ? 32'h0 : 32'h1e0,
          PIN_ALT);
      chk("rxd", 32'h1, UART_RXD);
      $display("test boot row %0d done", i);
    end
    // software pin write, short and long reset pin lows
    CFG_WR = 1'b1;
    cyc(1);
    CFG_WR = 1'b0;
    cyc(1);
    chk("cfg oe", DEF_OE | 32'h8, PIN_OE);
    chk("cfg pu", DEF_PU & ~32'h8, PIN_PULLUP);
    MODULE_RESET_LOW = 1'b0;
    cyc(3);
    MODULE_RESET_LOW = 1'b1;
    cyc(2);
    chk("short low", DEF_PU & ~32'h8, PIN_PULLUP);
    MODULE_RESET_LOW = 1'b0;
    cyc(12);
    CFG_WR = 1'b1;
    cyc(1);
    CFG_WR = 1'b0;
    MODULE_RESET_LOW = 1'b1;
    wait_valid();
    chk("hold pu", DEF_PU, PIN_PULLUP);
    chk("hold oe", DEF_OE, PIN_OE);
    $display("test pin config done");
    // uart flow control and data lines
    RTS_REQ = 1'b1;
    UART_TXD = 1'b0;
    hen[8:7] = 2'b11;
    hval[8:7] = 2'b10;
    cyc(3);
    chk("rts tx", 32'h0, PIN_OUT & 32'h60);
    chk("cts low", 32'h1, CTS_ASSERTED);
    hval[8:7] = 2'b01;
    cyc(3);
    chk("cts high", 32'h0, CTS_ASSERTED);
    chk("rx low", 32'h0, UART_RXD);
    $display("test uart done");
    // alternate functions drop their pulls
    I2C_OPEN = 1'b1;
    SPI_OPEN = 1'b1;
    OPEN_EXT_FLASH_CALL = 1'b1;
    UART_CLOSE = 1'b1;
    FLASH_SCK = 1'b1;
    hen[14] = 1'b1;
    hval[14] = 1'b1;
    cyc(3);
    chk("alt fn", 32'h0e11_5000, PIN_ALT);
    chk("pulls", 32'h0, (PIN_PULLUP | PIN_PULLDOWN) & 32'h0e11_5000);
    chk("flash sck", 32'h1_0000, PIN_OUT & 32'h1_0000);
    chk("flash so", 32'h1, FLASH_SO);
    $display("test alternate done");
    // calibration pulses over three periods
    for (int j = 0; j < 48; j++) begin
      cyc(1);
      k += int'(CAL_START);
    end
    chk("cal", 32'd3, k);
    $display("test calibration done");
    print_verdict();
  end
endmodule // tb_boot_strap_pin_defaults
